// ==== psl_regs.svh ====
// Register offsets, field positions and reset values of the port status block.
// Assumes a 32-bit AHB-Lite slave with word-aligned registers.
`ifndef PSL_REGS_SVH
`define PSL_REGS_SVH

`define PSL_ADDR_W 4
`define PSL_OFS_CTRL 4'h0
`define PSL_OFS_STATUS 4'h4
`define PSL_OFS_BLINK 4'h8

`define PSL_CTRL_XOVER 0
`define PSL_CTRL_TWO_LED 1
`define PSL_CTRL_AN_RESTART 2
`define PSL_CTRL_RST 32'h0000_0002

`define PSL_ST_PRESENT 0
`define PSL_ST_CARRIER 1
`define PSL_ST_TRAFFIC 2
`define PSL_ST_RST_SEEN 3
`define PSL_ST_PRES_LOST 4
`define PSL_ST_AN_DONE 5

`define PSL_BLINK_W 16
`define PSL_BLINK_RST 16'h0FFF

`endif

// ==== psl_pkg.sv ====
// Types shared by the port status block.
// Assumes the register header is compiled alongside.
`default_nettype none
package psl_pkg;
  typedef enum logic [2:0] {
    LED_OFF = 3'h1,
    LED_STEADY = 3'h2,
    LED_BLINK = 3'h4
  } psl_led_state_t;
endpackage
`default_nettype wire

// ==== psl_sync.sv ====
// Two-flop synchroniser for a group of pin levels.
// Assumes each bit is an independent level from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module psl_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      meta <= '0;
      o_sync <= '0;
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule
`default_nettype wire

// ==== psl_top.sv ====
// Port status block: reset sense, presence sense, serial path steering,
// Ethernet pair orientation, autonegotiation control and status LEDs.
// Assumes pins and PHY indications are asynchronous and an AHB-Lite master.
// Notes on behaviour
// - Host reset line raises reset-received indication.
// - Drive receives serial data from host.
// - Drive transmits serial data to host.
// - Ethernet connection always autonegotiates link speed.
// - Straight drives pair one, crossover pair two.
// - Link LED follows carrier; no carrier clears both.
// - Activity LED blinks on traffic, else off.
// - Single LED: off, steady, or blinking.
// - Presence sense detects attached automation device.
`timescale 1ns/1ps
`default_nettype none
`include "psl_regs.svh"
module psl_top (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic i_host_reset,
  input wire logic i_host_sense,
  input wire logic i_serial_rx_pin,
  input wire logic i_serial_tx_data,
  output logic o_serial_rx_data,
  output logic o_serial_tx_pin,
  input wire logic i_carrier,
  input wire logic i_tx_activity,
  input wire logic i_rx_activity,
  input wire logic i_an_done,
  output logic o_an_enable,
  output logic o_an_restart,
  output logic o_pair1_tx_en,
  output logic o_pair2_tx_en,
  output logic o_reset_received,
  output logic o_host_present,
  output logic o_link_led_out,
  output logic o_activity_led_out
);
  logic [5:0] pins;
  logic host_rst_s, sense_s, rx_n_s, rx_s, carrier_s, traffic_s, an_done_s;
  logic host_rst_d;
  logic present_d;
  logic [31:0] ctrl;
  logic [`PSL_BLINK_W-1:0] blink_div;
  logic rst_seen, pres_lost;
  logic wr_pend, rd_ok;
  logic [`PSL_ADDR_W-1:0] wr_addr;
  logic [`PSL_BLINK_W-1:0] blink_cnt;
  logic blink_phase;
  psl_pkg::psl_led_state_t led_state, next_led_state;
  logic addr_phase, wr_ctrl, wr_status, wr_blink;
  // Serial line idles high: it crosses inverted so reset reads as idle.
  psl_sync #(.WIDTH(6)) u_sync (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_async({i_host_reset, i_host_sense, ~i_serial_rx_pin, i_carrier,
              i_tx_activity | i_rx_activity, i_an_done}),
    .o_sync(pins)
  );
  assign {host_rst_s, sense_s, rx_n_s, carrier_s, traffic_s, an_done_s} = pins;
  assign rx_s = ~rx_n_s;
  function automatic logic hit(input logic [`PSL_ADDR_W-1:0] a,
                               input logic [`PSL_ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction
  // Bus slave: zero wait states, read data captured in the address phase.
  assign addr_phase = hsel & htrans[1] & hready;
  assign wr_ctrl = wr_pend & hit(wr_addr, `PSL_OFS_CTRL);
  assign wr_status = wr_pend & hit(wr_addr, `PSL_OFS_STATUS);
  assign wr_blink = wr_pend & hit(wr_addr, `PSL_OFS_BLINK);

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend <= addr_phase & hwrite;
      wr_addr <= haddr[`PSL_ADDR_W-1:0];
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  assign rd_ok = addr_phase & ~hwrite;
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_ok) begin
      if (hit(haddr[`PSL_ADDR_W-1:0], `PSL_OFS_CTRL)) begin
        hrdata <= ctrl;
      end else if (hit(haddr[`PSL_ADDR_W-1:0], `PSL_OFS_STATUS)) begin
        hrdata <= {26'h0, an_done_s, pres_lost, rst_seen, traffic_s,
                   carrier_s, sense_s};
      end else if (hit(haddr[`PSL_ADDR_W-1:0], `PSL_OFS_BLINK)) begin
        hrdata <= {16'h0, blink_div};
      end else begin
        hrdata <= 32'h0000_0000;
      end
    end
  end

  // The restart bit is self-clearing so software needs no second write.
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      ctrl <= `PSL_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl <= {29'h0, hwdata[2:0]};
    end else begin
      ctrl[`PSL_CTRL_AN_RESTART] <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      blink_div <= `PSL_BLINK_RST;
    end else if (wr_blink) begin
      blink_div <= hwdata[`PSL_BLINK_W-1:0];
    end
  end

  // Reset sense. The line is driven only by the automation side, so any
  // rising level is taken as a request.
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      host_rst_d <= 1'b0;
      o_reset_received <= 1'b0;
    end else begin
      host_rst_d <= host_rst_s;
      o_reset_received <= host_rst_s & ~host_rst_d;
    end
  end

  // Sticky flags, write one to clear; a new event wins over the clear.
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      rst_seen <= 1'b0;
    end else if (host_rst_s & ~host_rst_d) begin
      rst_seen <= 1'b1;
    end else if (wr_status & hwdata[`PSL_ST_RST_SEEN]) begin
      rst_seen <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      present_d <= 1'b0;
      o_host_present <= 1'b0;
      pres_lost <= 1'b0;
    end else begin
      present_d <= sense_s;
      o_host_present <= sense_s;
      if (present_d & ~sense_s) begin
        pres_lost <= 1'b1;
      end else if (wr_status & hwdata[`PSL_ST_PRES_LOST]) begin
        pres_lost <= 1'b0;
      end
    end
  end

  // Serial paths: host-to-drive is received, drive-to-host is sent.
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_serial_rx_data <= 1'b1;
      o_serial_tx_pin <= 1'b1;
    end else begin
      o_serial_rx_data <= rx_s;
      o_serial_tx_pin <= i_serial_tx_data;
    end
  end
  // Pair orientation and autonegotiation; the pair enables also gate
  // off both drivers while reset holds, so the link never sees a glitch.
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_pair1_tx_en <= 1'b0;
      o_pair2_tx_en <= 1'b0;
      o_an_enable <= 1'b0;
      o_an_restart <= 1'b0;
    end else begin
      o_pair1_tx_en <= ~ctrl[`PSL_CTRL_XOVER];
      o_pair2_tx_en <= ctrl[`PSL_CTRL_XOVER];
      o_an_enable <= 1'b1;
      o_an_restart <= ctrl[`PSL_CTRL_AN_RESTART];
    end
  end
  // Blink divider: the phase flips every blink_div+1 cycles of traffic.
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      blink_cnt <= '0;
      blink_phase <= 1'b0;
    end else if (led_state != psl_pkg::LED_BLINK) begin
      blink_cnt <= '0;
      blink_phase <= 1'b0;
    end else if (blink_cnt >= blink_div) begin
      blink_cnt <= '0;
      blink_phase <= ~blink_phase;
    end else begin
      blink_cnt <= blink_cnt + 1'b1;
    end
  end
  always_comb begin
    case (led_state)
      psl_pkg::LED_OFF,
      psl_pkg::LED_STEADY,
      psl_pkg::LED_BLINK: begin
        if (!carrier_s) begin
          next_led_state = psl_pkg::LED_OFF;
        end else if (traffic_s) begin
          next_led_state = psl_pkg::LED_BLINK;
        end else begin
          next_led_state = psl_pkg::LED_STEADY;
        end
      end
      default: begin
        next_led_state = psl_pkg::LED_OFF;
      end
    endcase
  end
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      led_state <= psl_pkg::LED_OFF;
    end else begin
      led_state <= next_led_state;
    end
  end
  // LED drivers: high means the open-collector output sinks current.
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_link_led_out <= 1'b0;
      o_activity_led_out <= 1'b0;
    end else if (ctrl[`PSL_CTRL_TWO_LED]) begin
      o_link_led_out <= (led_state != psl_pkg::LED_OFF);
      o_activity_led_out <= (led_state == psl_pkg::LED_BLINK) &
                            blink_phase;
    end else begin
      o_activity_led_out <= 1'b0;
      case (led_state)
        psl_pkg::LED_STEADY: o_link_led_out <= 1'b1;
        psl_pkg::LED_BLINK: o_link_led_out <= ~blink_phase;
        default: o_link_led_out <= 1'b0;
      endcase
    end
  end
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_sys_rst);
  sequence rst_edge_s;
    host_rst_s & ~host_rst_d;
  endsequence
  reset_pulse_a: assert property (rst_edge_s |=> o_reset_received)
    else $error("reset edge gave no indication");
  reset_once_a: assert property (
    o_reset_received |=> !o_reset_received)
    else $error("reset indication longer than one cycle");
  rst_sticky_a: assert property (rst_edge_s |=> rst_seen)
    else $error("reset flag not set");
  serial_rx_a: assert property (o_serial_rx_data == $past(rx_s))
    else $error("serial receive path not passed");
  serial_tx_a: assert property (
    !$past(i_sys_rst) |-> o_serial_tx_pin == $past(i_serial_tx_data))
    else $error("serial transmit path not passed");
  an_on_a: assert property (!$past(i_sys_rst) |-> o_an_enable)
    else $error("autonegotiation disabled");
  pair_excl_a: assert property (
    !$past(i_sys_rst) |-> o_pair2_tx_en == $past(ctrl[`PSL_CTRL_XOVER]) &&
    o_pair1_tx_en == !o_pair2_tx_en)
    else $error("wrong pair driven for the wiring");
  no_carrier_a: assert property (
    !carrier_s ##2 1 |-> !o_link_led_out && !o_activity_led_out)
    else $error("LED lit without carrier");
  idle_act_a: assert property (
    carrier_s && !traffic_s ##1 !traffic_s |=> !o_activity_led_out)
    else $error("activity LED lit without traffic");
  steady_a: assert property (
    !ctrl[`PSL_CTRL_TWO_LED] && carrier_s && !traffic_s ##1
    carrier_s && !traffic_s |=> o_link_led_out)
    else $error("single LED not steady while idle");
  presence_a: assert property (o_host_present == $past(sense_s))
    else $error("presence not reported");
  blink_wrap_a: assert property (
    led_state == psl_pkg::LED_BLINK && blink_cnt >= blink_div
    |=> $changed(blink_phase))
    else $error("blink phase missed its period");
endmodule
`default_nettype wire

// ==== psl_host_model.sv ====
// Behavioural automation device facing the drive's port status block.
// Assumes the bench commands it in the reference clock domain.
`timescale 1ns/1ps
`default_nettype none
module psl_host_model (
  input wire logic i_ref_clk,
  input wire logic i_do_reset,
  input wire logic i_present,
  input wire logic i_send_bit,
  input wire logic i_rx_line,
  output logic o_reset_line,
  output logic o_sense_line,
  output logic o_tx_line,
  output logic o_got_bit
);
  // Only this side ever drives the reset line; released means low.
  always_ff @(posedge i_ref_clk) begin
    o_reset_line <= i_do_reset;
    o_sense_line <= i_present;
  end
  always_ff @(posedge i_ref_clk) begin
    o_tx_line <= i_send_bit;
    o_got_bit <= i_rx_line;
  end
endmodule
`default_nettype wire

// ==== tb.sv ====
// Self-checking bench for the port status block.
// Assumes the design files and register header are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "psl_regs.svh"
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin \
  errors++; $display("wrong value %s exp %h got %h", nm, exp, got); end end
module tb;
  localparam logic [31:0] A_CTRL = 32'(`PSL_OFS_CTRL);
  localparam logic [31:0] A_STAT = 32'(`PSL_OFS_STATUS);
  localparam logic [31:0] A_BLNK = 32'(`PSL_OFS_BLINK);
  logic clk, rst, hwrite, hrdy, hresp, rxd, txpin, tx_data, carrier, txa;
  logic rxa, an_done, an_en, an_rst, p1, p2, rr, pres, link, act, do_rst;
  logic present, send_bit, host_rst, sense, line_in, got_bit;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  int errors, checked, n;
  psl_top uut (.i_ref_clk(clk), .i_sys_rst(rst), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy), .hresp(hresp),
    .hrdata(hrdata), .i_host_reset(host_rst), .i_host_sense(sense),
    .i_serial_rx_pin(line_in), .i_serial_tx_data(tx_data),
    .o_serial_rx_data(rxd), .o_serial_tx_pin(txpin), .i_carrier(carrier),
    .i_tx_activity(txa), .i_rx_activity(rxa), .i_an_done(an_done),
    .o_an_enable(an_en), .o_an_restart(an_rst), .o_pair1_tx_en(p1),
    .o_pair2_tx_en(p2), .o_reset_received(rr), .o_host_present(pres),
    .o_link_led_out(link), .o_activity_led_out(act));
  psl_host_model host (.i_ref_clk(clk), .i_do_reset(do_rst),
    .i_present(present), .i_send_bit(send_bit), .i_rx_line(txpin),
    .o_reset_line(host_rst), .o_sense_line(sense), .o_tx_line(line_in),
    .o_got_bit(got_bit));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic step(input int k);
    repeat (k) @(posedge clk);
  endtask
  // Holds each phase until hready is seen high; read data taken there.
  task automatic bus(input logic w, input logic [31:0] a, d);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    rd = hrdata;
  endtask
  function automatic logic led(input bit use_link);
    return use_link ? link : act;
  endfunction
  // Cycles between two successive changes of a blinking LED.
  task automatic period(input bit use_link, output int p);
    logic v;
    int k;
    v = led(use_link);
    k = 0;
    while (led(use_link) === v && k < 60) begin
      @(posedge clk);
      k++;
    end
    v = led(use_link);
    p = 0;
    while (led(use_link) === v && p < 60) begin
      @(posedge clk);
      p++;
    end
  endtask
  task automatic t_regs();
    bus(0, A_CTRL, 0); `CHK("ctrl", `PSL_CTRL_RST, rd)
    bus(0, A_BLNK, 0); `CHK("blink", 32'(`PSL_BLINK_RST), rd)
    bus(0, 32'hC, 0); `CHK("unmapped", 32'h0, rd)
    `CHK("an_en", 1'b1, an_en)
    `CHK("pair1", 1'b1, p1)
    `CHK("pair2", 1'b0, p2)
    bus(1, A_CTRL, 32'h3);
    step(2);
    `CHK("pair1 x", 1'b0, p1)
    `CHK("pair2 x", 1'b1, p2)
    bus(1, A_CTRL, 32'h7);
    n = 0;
    repeat (6) begin
      @(posedge clk);
      n += int'(an_rst === 1'b1);
    end
    `CHK("restart", 1, n)
    bus(0, A_CTRL, 0); `CHK("ctrl sc", 32'h3, rd)
    bus(1, A_CTRL, 32'h2);
  endtask
  task automatic t_sense();
    present <= 1'b1;
    an_done <= 1'b1;
    do_rst <= 1'b1;
    n = 0;
    repeat (12) begin
      @(posedge clk);
      n += int'(rr === 1'b1);
    end
    `CHK("rst pulses", 1, n)
    `CHK("present", 1'b1, pres)
    bus(0, A_STAT, 0); `CHK("st", 32'h29, rd & 32'h39)
    do_rst <= 1'b0;
    present <= 1'b0;
    step(6);
    `CHK("absent", 1'b0, pres)
    bus(1, A_STAT, 32'h8);
    bus(0, A_STAT, 0); `CHK("st w1c", 32'h10, rd & 32'h19)
  endtask
  task automatic t_serial();
    tx_data <= 1'b0;
    send_bit <= 1'b0;
    step(2);
    `CHK("tx pin", 1'b0, txpin)
    step(4);
    `CHK("host got", 1'b0, got_bit)
    `CHK("rx data", 1'b0, rxd)
    tx_data <= 1'b1;
    send_bit <= 1'b1;
    step(6);
    `CHK("rx idle", 1'b1, rxd)
  endtask
  task automatic t_leds();
    bus(1, A_BLNK, 32'h3);
    step(6);
    `CHK("no carrier", 2'b00, {link, act})
    carrier <= 1'b1;
    step(6);
    `CHK("carrier", 2'b10, {link, act})
    txa <= 1'b1;
    period(0, n);
    `CHK("act period", 4, n)
    carrier <= 1'b0;
    step(6);
    `CHK("drop", 2'b00, {link, act})
    carrier <= 1'b1;
    txa <= 1'b0;
    step(8);
    `CHK("idle act", 2'b10, {link, act})
    bus(1, A_CTRL, 32'h0);
    step(6);
    `CHK("single", 1'b1, link)
    rxa <= 1'b1;
    period(1, n);
    `CHK("link period", 4, n)
    bus(0, A_STAT, 0); `CHK("st link", 32'h6, rd & 32'h6)
    carrier <= 1'b0;
    step(6);
    `CHK("single off", 1'b0, link)
  endtask
  task automatic results();
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    hwrite = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    tx_data = 1'b1;
    carrier = 1'b0;
    txa = 1'b0;
    rxa = 1'b0;
    an_done = 1'b0;
    do_rst = 1'b0;
    present = 1'b0;
    send_bit = 1'b1;
    errors = 0;
    checked = 0;
    step(10);
    rst <= 1'b0;
    step(2);
    t_regs();
    t_sense();
    t_serial();
    t_leds();
    results();
  end
  initial begin
    step(5000);
    errors++;
    results();
  end
endmodule
`default_nettype wire
